// ### verilog/kbd_cfg_select.sv
// keyboard controller configuration select register with line isolation and interrupt latching
//
// Function
// RULE1: select bit 7 sets auxiliary output polarity; 0 active low, 1 active high.
// RULE2: bit 6 set blocks mouse clock and data into core; clear passes them.
// RULE3: mouse isolation never touches the mouse data line to wake-up logic.
// RULE4: bit 5 set blocks keyboard clock and data into core; clear passes them.
// RULE5: keyboard isolation never touches the keyboard data line to wake-up logic.
// RULE6: bit 4 clear: mouse irq is raw AND latched; set: latched only.
// RULE7: bit 3 clear: keyboard irq is raw AND latched; set: latched only.
// RULE8: bit 2 disables port 92 when 0, enables it when 1.
// RULE9: select bits 1 and 0 are reserved with no function.
// RULE10: indices 0xF1 to 0xFF are reserved and read as zero.
// RULE11: isolated core clock and data inputs are held at idle high.
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module kbd_cfg_select
  import kbd_cfg_pkg::*;
#(
  parameter int unsigned ADDR_W = 32
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          arst_n,
  // ahb-lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  // keyboard and mouse lines
  input  wire kbd_lines_type lines_pin,
  output kbd_lines_type      core_lines,
  output logic               wake_mouse_data,
  output logic               wake_keyboard_data,
  // keyboard core side
  input  wire logic          core_aux_bit2,
  input  wire logic          core_mouse_irq,
  input  wire logic          core_keyboard_irq,
  input  wire logic [1:0]    irq_latch_clear,
  // outputs to the system
  output logic               core_aux_output_bit2,
  output logic               mouse_irq,
  output logic               keyboard_irq,
  output logic               port92_enable,
  output logic               irq
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (ADDR_W < IDX_MSB + 1 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 10 and 32");
  end

  kbd_state_type st_ff;
  kbd_state_type nxt_st;
  logic [1:0]    raw_irq;
  logic [1:0]    out_irq;
  logic [3:0]    iso_mask;
  logic          ap_ok;
  logic [1:0]    lat_only;
  logic          hi_zero;

  // ---------------------------------------------------------------
  // read multiplexer
  // ---------------------------------------------------------------
  function automatic logic [31:0] rd_value(input kbd_state_type s);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (s.ap_valid) begin
      case (s.ap_idx)
        IDX_SELECT:     v = {24'h00_0000, s.sel};
        IDX_IRQ_STATUS: v = {30'h0000_0000, s.status};
        IDX_IRQ_MASK:   v = {30'h0000_0000, s.mask};
        default:        v = 32'h0000_0000; // RULE10
      endcase
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // combinational outputs
  // ---------------------------------------------------------------
  assign raw_irq = {core_keyboard_irq, core_mouse_irq};

  // default keeps the pulse gated by the latch; latched-only mode stretches it
  assign lat_only[EV_MOUSE] = st_ff.sel[SEL_MOUSE_LAT]; // RULE6
  assign lat_only[EV_KBD]   = st_ff.sel[SEL_KBD_LAT]; // RULE7
  for (genvar i = 0; i < 2; i++) begin : g_irq_out
    assign out_irq[i] = lat_only[i] ? st_ff.latch[i]
                      : (raw_irq[i] & st_ff.latch[i]); // RULE6 RULE7
  end

  assign iso_mask = {{2{st_ff.sel[SEL_KBD_ISO]}}, {2{st_ff.sel[SEL_MOUSE_ISO]}}};
  // isolated lines read as idle so the core decodes no spurious bits
  assign core_lines = kbd_lines_type'(st_ff.filt | iso_mask); // RULE2 RULE4 RULE11
  // wake-up taps come straight from the filtered pins, ahead of isolation
  assign wake_mouse_data    = st_ff.filt[1]; // RULE3
  assign wake_keyboard_data = st_ff.filt[3]; // RULE5

  assign core_aux_output_bit2 = st_ff.sel[SEL_AUX_POL] ? core_aux_bit2 : ~core_aux_bit2; // RULE1
  assign mouse_irq     = out_irq[EV_MOUSE];
  assign keyboard_irq  = out_irq[EV_KBD];
  assign port92_enable = st_ff.sel[SEL_PORT92]; // RULE8
  assign irq           = |(st_ff.status & st_ff.mask);

  assign hreadyout = ~st_ff.rd_wait;
  assign hresp     = 1'b0;
  assign hrdata    = st_ff.rdata;

  // with the narrowest bus there are no bits left above the index to check
  if (ADDR_W > IDX_MSB + 1) begin : g_hi_chk
    assign hi_zero = (haddr[ADDR_W-1:IDX_MSB+1] == '0);
  end else begin : g_hi_none
    assign hi_zero = 1'b1;
  end

  assign ap_ok = (haddr[1:0] == 2'b00) && (hsize == HSIZE_WORD) && hi_zero;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // three-stage sampler; a level is taken once stages two and three agree
    nxt_st.s1 = lines_pin;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.filt = st_ff.s3;
    end

    // core interrupt latches: a new request wins over a clear in the same cycle
    for (int i = 0; i < 2; i++) begin
      if (raw_irq[i]) begin
        nxt_st.latch[i] = 1'b1;
      end else if (irq_latch_clear[i]) begin
        nxt_st.latch[i] = 1'b0;
      end
    end

    // data phase of a write
    if (st_ff.ap_valid && st_ff.ap_write) begin
      case (st_ff.ap_idx)
        IDX_SELECT:     nxt_st.sel = hwdata[7:0] & SEL_WMASK; // RULE9
        IDX_IRQ_STATUS: nxt_st.status = st_ff.status & ~hwdata[1:0];
        IDX_IRQ_MASK:   nxt_st.mask = hwdata[1:0];
        default:        nxt_st.sel = st_ff.sel; // RULE10
      endcase
    end

    // rising interrupt outputs set sticky status; set beats write-one-clear
    nxt_st.prev   = out_irq;
    nxt_st.status = nxt_st.status | (out_irq & ~st_ff.prev);

    // reads cost one wait state so a write just before is already visible
    if (st_ff.rd_wait) begin
      nxt_st.rdata   = rd_value(st_ff);
      nxt_st.rd_wait = 1'b0;
    end

    // address phase
    if (hready) begin
      nxt_st.ap_valid = 1'b0;
      nxt_st.ap_write = 1'b0;
      if (hsel && htrans[1]) begin
        nxt_st.ap_valid = ap_ok;
        nxt_st.ap_write = hwrite;
        nxt_st.ap_idx   = haddr[IDX_MSB:IDX_LSB];
        nxt_st.rd_wait  = ~hwrite;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_ff.s1       <= LINES_IDLE;
      st_ff.s2       <= LINES_IDLE;
      st_ff.s3       <= LINES_IDLE;
      st_ff.filt     <= LINES_IDLE;
      st_ff.sel      <= SEL_RESET;
      st_ff.latch    <= EV_RESET;
      st_ff.prev     <= EV_RESET;
      st_ff.status   <= EV_RESET;
      st_ff.mask     <= EV_RESET;
      st_ff.ap_valid <= 1'b0;
      st_ff.ap_write <= 1'b0;
      st_ff.rd_wait  <= 1'b0;
      st_ff.ap_idx   <= 8'h00;
      st_ff.rdata    <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  aux_polarity_a: assert property ( // RULE1
    (st_ff.ap_valid && st_ff.ap_write && st_ff.ap_idx == IDX_SELECT)
      |=> core_aux_output_bit2 == ($past(hwdata[SEL_AUX_POL]) ^ ~core_aux_bit2))
    else $error("aux output polarity does not follow select bit 7");

  mouse_block_a: assert property ( // RULE2
    st_ff.sel[SEL_MOUSE_ISO] |-> (core_lines.mouse_clk && core_lines.mouse_data))
    else $error("isolated mouse lines not held high toward core");

  mouse_pass_a: assert property ( // RULE2
    (!st_ff.sel[SEL_MOUSE_ISO] && $stable(lines_pin.mouse_data)) [*4]
      |-> core_lines.mouse_data == lines_pin.mouse_data)
    else $error("mouse data not passed to core when not isolated");

  mouse_wake_a: assert property ( // RULE3
    $stable(lines_pin.mouse_data) [*4] |-> wake_mouse_data == lines_pin.mouse_data)
    else $error("mouse wake data affected by isolation");

  kbd_block_a: assert property ( // RULE4
    st_ff.sel[SEL_KBD_ISO] |-> (core_lines.kbd_clk && core_lines.kbd_data))
    else $error("isolated keyboard lines not held high toward core");

  kbd_wake_a: assert property ( // RULE5
    $stable(lines_pin.kbd_data) [*4] |-> wake_keyboard_data == lines_pin.kbd_data)
    else $error("keyboard wake data affected by isolation");

  mouse_latch_a: assert property ( // RULE6
    (st_ff.sel[SEL_MOUSE_LAT] && core_mouse_irq)
      |=> mouse_irq == (st_ff.sel[SEL_MOUSE_LAT] || core_mouse_irq))
    else $error("latched mouse interrupt not raised");

  kbd_gate_a: assert property ( // RULE7
    (!st_ff.sel[SEL_KBD_LAT] && !core_keyboard_irq) |-> !keyboard_irq)
    else $error("keyboard interrupt high without raw request in default mode");

  port92_sel_a: assert property ( // RULE8
    (st_ff.ap_valid && st_ff.ap_write && st_ff.ap_idx == IDX_SELECT)
      |=> port92_enable == $past(hwdata[SEL_PORT92]))
    else $error("port 92 enable does not follow select bit 2");

  rsvd_bits_a: assert property ( // RULE9
    st_ff.sel[1:0] == 2'b00)
    else $error("reserved select bits stored");

  rsvd_read_a: assert property ( // RULE10
    (st_ff.rd_wait && st_ff.ap_idx >= IDX_RSVD_FIRST) ##1 hreadyout |-> hrdata == 32'h0000_0000)
    else $error("reserved index read non-zero");

  // ---------------------------------------------------------------
  // line pass-through with isolation clear
  // ---------------------------------------------------------------
  // clock lines are checked apart from data since a swapped pair would pass a data-only check
  mouse_clk_pass_a: assert property ( // RULE2
    (!st_ff.sel[SEL_MOUSE_ISO] && $stable(lines_pin.mouse_clk)) [*4]
      |-> core_lines.mouse_clk == lines_pin.mouse_clk)
    else $error("mouse clock not passed to core when not isolated");

  kbd_pass_a: assert property ( // RULE4
    (!st_ff.sel[SEL_KBD_ISO] && $stable(lines_pin.kbd_data)) [*4]
      |-> core_lines.kbd_data == lines_pin.kbd_data)
    else $error("keyboard data not passed to core when not isolated");

  kbd_clk_pass_a: assert property ( // RULE4
    (!st_ff.sel[SEL_KBD_ISO] && $stable(lines_pin.kbd_clk)) [*4]
      |-> core_lines.kbd_clk == lines_pin.kbd_clk)
    else $error("keyboard clock not passed to core when not isolated");

  // ---------------------------------------------------------------
  // aux output polarity, interrupt outputs and sticky status
  // ---------------------------------------------------------------
  aux_default_a: assert property ( // RULE1
    !st_ff.sel[SEL_AUX_POL] |-> core_aux_output_bit2 == !core_aux_bit2)
    else $error("aux output not inverted with select bit 7 clear");

  mouse_gate_a: assert property ( // RULE6
    (!st_ff.sel[SEL_MOUSE_LAT] && !core_mouse_irq) |-> !mouse_irq)
    else $error("mouse interrupt high without raw request in default mode");

  kbd_latch_a: assert property ( // RULE7
    (st_ff.sel[SEL_KBD_LAT] && core_keyboard_irq)
      |=> keyboard_irq == (st_ff.sel[SEL_KBD_LAT] || core_keyboard_irq))
    else $error("latched keyboard interrupt not raised");

  mouse_status_a: assert property (
    $rose(mouse_irq) |=> st_ff.status[EV_MOUSE])
    else $error("rising mouse interrupt did not set status");

  kbd_status_a: assert property (
    $rose(keyboard_irq) |=> st_ff.status[EV_KBD])
    else $error("rising keyboard interrupt did not set status");

  // a clear that meets a new rising edge must lose, so such cycles are left out
  status_w1c_a: assert property (
    (st_ff.ap_valid && st_ff.ap_write && st_ff.ap_idx == IDX_IRQ_STATUS
      && hwdata[EV_MOUSE] && !$rose(mouse_irq)) |=> !st_ff.status[EV_MOUSE])
    else $error("write of one did not clear mouse status");

  irq_raise_a: assert property (
    (st_ff.status[EV_KBD] && st_ff.mask[EV_KBD]) |-> irq)
    else $error("unmasked keyboard status did not raise irq");

  irq_quiet_a: assert property (
    (st_ff.mask == 2'b00) |-> !irq)
    else $error("irq high with every source masked");

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  read_wait_a: assert property (
    (hsel && hready && htrans[1] && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state long");

  write_nowait_a: assert property (
    (hsel && hready && htrans[1] && hwrite) |=> hreadyout)
    else $error("write data phase stalled");

  rdata_hold_a: assert property (
    !st_ff.rd_wait |=> $stable(hrdata))
    else $error("read data changed outside a read");

  port92_hold_a: assert property ( // RULE8
    !(st_ff.ap_valid && st_ff.ap_write && st_ff.ap_idx == IDX_SELECT) |=> $stable(port92_enable))
    else $error("port 92 enable changed without a select write");

  rsvd_write_a: assert property ( // RULE10
    (st_ff.ap_valid && st_ff.ap_write && st_ff.ap_idx >= IDX_RSVD_FIRST) |=> $stable(st_ff.sel))
    else $error("write to reserved index changed the select register");

endmodule : kbd_cfg_select

`default_nettype wire

// ### verilog/kbd_cfg_pkg.sv
// package: register map, field positions and state types of the keyboard configuration block
package kbd_cfg_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [7:0]  IDX_IRQ_STATUS = 8'h00;
  localparam logic [7:0]  IDX_IRQ_MASK   = 8'h01;
  localparam logic [7:0]  IDX_SELECT     = 8'hF0;
  localparam logic [7:0]  IDX_RSVD_FIRST = 8'hF1;
  localparam logic [7:0]  IDX_RSVD_LAST  = 8'hFF;
  localparam int unsigned IDX_LSB        = 2;
  localparam int unsigned IDX_MSB        = 9;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;

  // ---------------------------------------------------------------
  // select register fields
  // ---------------------------------------------------------------
  localparam int unsigned SEL_AUX_POL    = 7;
  localparam int unsigned SEL_MOUSE_ISO  = 6;
  localparam int unsigned SEL_KBD_ISO    = 5;
  localparam int unsigned SEL_MOUSE_LAT  = 4;
  localparam int unsigned SEL_KBD_LAT    = 3;
  localparam int unsigned SEL_PORT92     = 2;
  localparam logic [7:0]  SEL_RESET      = 8'h00;
  localparam logic [7:0]  SEL_WMASK      = 8'hFC;

  // ---------------------------------------------------------------
  // interrupt status / mask bit positions
  // ---------------------------------------------------------------
  localparam int unsigned EV_MOUSE       = 0;
  localparam int unsigned EV_KBD         = 1;
  localparam logic [1:0]  EV_RESET       = 2'h0;

  // line level at idle; lines are open-drain and pulled high
  localparam logic [3:0]  LINES_IDLE     = 4'hF;

  typedef struct packed {
    logic kbd_data;
    logic kbd_clk;
    logic mouse_data;
    logic mouse_clk;
  } kbd_lines_type;

  typedef struct packed {
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic [3:0]  s3;
    logic [3:0]  filt;
    logic [7:0]  sel;
    logic [1:0]  latch;
    logic [1:0]  prev;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        ap_valid;
    logic        ap_write;
    logic        rd_wait;
    logic [7:0]  ap_idx;
    logic [31:0] rdata;
  } kbd_state_type;

endpackage : kbd_cfg_pkg

// ### testbench/tb.sv
// self-checking testbench for the keyboard configuration select block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import kbd_cfg_pkg::*;

  logic          clock;
  logic          arst_n;
  logic          hsel;
  logic          hwrite;
  logic [1:0]    htrans;
  logic [31:0]   haddr;
  logic [31:0]   hwdata;
  logic [31:0]   hrdata;
  logic [31:0]   rd;
  logic          hready;
  logic          hresp;
  kbd_lines_type lines_pin;
  kbd_lines_type core_lines;
  logic          wake_mouse_data;
  logic          wake_keyboard_data;
  logic          core_aux_bit2;
  logic          core_mouse_irq;
  logic          core_keyboard_irq;
  logic [1:0]    irq_latch_clear;
  logic          core_aux_output_bit2;
  logic          mouse_irq;
  logic          keyboard_irq;
  logic          port92_enable;
  logic          irq;
  int            failures;
  int            cmp_count;
  logic [7:0]    iso_sel [4] = '{8'h60, 8'h40, 8'h20, 8'h00};
  logic [3:0]    iso_exp [4] = '{4'hF, 4'h3, 4'hC, 4'h0};

  kbd_cfg_select kbd_cfg_select_i (
    .clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .lines_pin(lines_pin),
    .core_lines(core_lines), .wake_mouse_data(wake_mouse_data),
    .wake_keyboard_data(wake_keyboard_data), .core_aux_bit2(core_aux_bit2),
    .core_mouse_irq(core_mouse_irq), .core_keyboard_irq(core_keyboard_irq),
    .irq_latch_clear(irq_latch_clear), .core_aux_output_bit2(core_aux_output_bit2),
    .mouse_irq(mouse_irq), .keyboard_irq(keyboard_irq), .port92_enable(port92_enable), .irq(irq));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask

  // hready and hrdata are read right after the edge, before the design's flops update
  task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] d);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge clock);
    end while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clock);
    end while (hready !== 1'b1);
    rd = hrdata;
    check1(hresp, 1'b0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    htrans = 2'h0;
    hwdata = 32'h0000_0000;
    lines_pin = LINES_IDLE;
    core_aux_bit2 = 1'b0;
    core_mouse_irq = 1'b0;
    core_keyboard_irq = 1'b0;
    irq_latch_clear = 2'h0;
    failures = 0;
    cmp_count = 0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    settle(1);
    check1(port92_enable, 1'b0);
    check({28'h0, core_lines}, 32'h0000_000F);
    rdchk(IDX_SELECT, 32'h0000_0000);
    rdchk(IDX_IRQ_MASK, 32'h0000_0000);
    done("reset");
    wr(IDX_SELECT, 32'hFFFF_FFFF);
    rdchk(IDX_SELECT, 32'h0000_00FC);
    check1(port92_enable, 1'b1);
    wr(IDX_SELECT, 32'h0000_00FB);
    settle(1);
    check1(port92_enable, 1'b0);
    done("select");
    for (int p = 0; p < 2; p++) begin
      wr(IDX_SELECT, p ? 32'h0000_0080 : 32'h0000_0000);
      for (int v = 0; v < 2; v++) begin
        @(posedge clock);
        core_aux_bit2 <= v[0];
        settle(1);
        check1(core_aux_output_bit2, p ? v[0] : ~v[0]);
      end
    end
    done("polarity");
    @(posedge clock);
    lines_pin <= 4'h0;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_SELECT, {24'h0, iso_sel[i]});
      settle(6);
      check({28'h0, core_lines}, {28'h0, iso_exp[i]});
      check1(wake_mouse_data, 1'b0);
      check1(wake_keyboard_data, 1'b0);
    end
    @(posedge clock);
    lines_pin <= LINES_IDLE;
    settle(6);
    check({28'h0, core_lines}, 32'h0000_000F);
    check1(wake_mouse_data, 1'b1);
    check1(wake_keyboard_data, 1'b1);
    done("isolation");
    wr(IDX_SELECT, 32'h0000_0018);
    @(posedge clock);
    core_mouse_irq <= 1'b1;
    core_keyboard_irq <= 1'b1;
    @(posedge clock);
    core_mouse_irq <= 1'b0;
    core_keyboard_irq <= 1'b0;
    settle(3);
    check1(mouse_irq, 1'b1);
    check1(keyboard_irq, 1'b1);
    check1(irq, 1'b0);
    rdchk(IDX_IRQ_STATUS, 32'h0000_0003);
    wr(IDX_IRQ_MASK, 32'h0000_0001);
    settle(1);
    check1(irq, 1'b1);
    wr(IDX_SELECT, 32'h0000_0000);
    settle(1);
    check1(mouse_irq, 1'b0);
    check1(keyboard_irq, 1'b0);
    @(posedge clock);
    core_mouse_irq <= 1'b1;
    settle(2);
    check1(mouse_irq, 1'b1);
    @(posedge clock);
    core_mouse_irq <= 1'b0;
    irq_latch_clear <= 2'h3;
    @(posedge clock);
    irq_latch_clear <= 2'h0;
    wr(IDX_SELECT, 32'h0000_0018);
    settle(1);
    check1(mouse_irq, 1'b0);
    check1(keyboard_irq, 1'b0);
    wr(IDX_IRQ_STATUS, 32'h0000_0001);
    rdchk(IDX_IRQ_STATUS, 32'h0000_0002);
    check1(irq, 1'b0);
    done("interrupts");
    for (int i = IDX_RSVD_FIRST; i <= IDX_RSVD_LAST; i++) begin
      wr(i[7:0], 32'hFFFF_FFFF);
      rdchk(i[7:0], 32'h0000_0000);
    end
    rdchk(8'h80, 32'h0000_0000);
    rdchk(IDX_SELECT, 32'h0000_0018);
    done("reserved");
    summarize();
  end

  // whole run takes well under a thousand cycles
  initial begin
    #400000;
    failures++;
    summarize();
  end

endmodule // tb

`default_nettype wire
